// >>> hw/vmx_ctrl.sv
/*
 * vmx_ctrl: control registers and mode logic of a 4x4 video switch matrix.
 * assumes: straps are static levels; scl/sda come from pins, outside this clock.
 */
`timescale 1ns/10ps
`default_nettype none
module vmx_ctrl
    import vmx_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic i_addr_strap_0,
    input wire logic i_addr_strap_1,
    input wire logic i_addr_strap_2,
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic [7:0] o_input_routing,
    output logic [3:0] o_out_gain_sel,
    output logic [3:0] o_clamp_en,
    output logic [3:0] o_out_drive_en,
    output logic o_aux_logic_out_a,
    output logic o_aux_logic_out_a_oe,
    output logic o_aux_logic_out_b,
    output logic o_aux_logic_out_b_oe,
    output logic o_standalone
);
    logic [2:0] strap_s1_r, strap_s2_r;
    logic mode_valid_r, mode_valid_nxt, standalone_r, standalone_nxt;
    logic scl_s, sda_s, sda_oe_c, sub_v, dat_v;
    logic [7:0] rx_byte;
    logic [1:0] idx_r, idx_nxt;
    logic [7:0] route_r, route_nxt, gca_r, gca_nxt;
    logic [3:0] oen_r, oen_nxt;
    logic [7:0] o_route_nxt;
    logic [3:0] o_gain_nxt, o_clamp_nxt, o_en_nxt;
    logic aux_a_oe_nxt, aux_b_oe_nxt;
    logic sda_oe_r, first_r;
    logic [1:0] settle_r, settle_nxt;

    // straps pass two flops, then mode is caught once after reset release
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
        end else begin
            strap_s1_r <= {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
            strap_s2_r <= strap_s1_r;
        end
    end

    vmx_i2c_rx u_rx (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_scl(i_scl),
        .i_sda_in(i_sda_in),
        .i_enable(mode_valid_r & ~standalone_r),
        .i_addr_lo(strap_s2_r),
        .o_scl_sync(scl_s),
        .o_sda_sync(sda_s),
        .o_sda_oe(sda_oe_c),
        .o_sub_valid(sub_v),
        .o_data_valid(dat_v),
        .o_byte(rx_byte)
    );

    // index select and register writes; standalone never sees pulses
    always_comb begin
        // the strap chain resets to zero, so the mode waits until it has refilled
        settle_nxt = (settle_r == VMX_MODE_SETTLE) ? settle_r : settle_r + 2'h1;
        mode_valid_nxt = mode_valid_r | (settle_r == VMX_MODE_SETTLE);
        standalone_nxt = mode_valid_r ? standalone_r : &strap_s2_r;
        idx_nxt = idx_r;
        route_nxt = route_r;
        gca_nxt = gca_r;
        oen_nxt = oen_r;
        if (sub_v) begin
            idx_nxt = rx_byte[1:0];
        end else if (dat_v) begin
            case (idx_r)
                VMX_IDX_ROUTE: route_nxt = rx_byte;
                VMX_IDX_GCA: gca_nxt = rx_byte;
                VMX_IDX_OEN: oen_nxt = rx_byte[VMX_OEN_W-1:0];
                default: route_nxt = route_r;
            endcase
            // index 3 is not a register: it writes nothing and wraps too
            idx_nxt = (idx_r >= VMX_IDX_LAST) ? VMX_IDX_ROUTE : idx_r + 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            settle_r <= 2'h0;
            mode_valid_r <= 1'b0;
            standalone_r <= 1'b0;
            idx_r <= VMX_IDX_ROUTE;
            route_r <= VMX_ROUTE_RST;
            gca_r <= VMX_GCA_RST;
            oen_r <= VMX_OEN_RST;
        end else begin
            settle_r <= settle_nxt;
            mode_valid_r <= mode_valid_nxt;
            standalone_r <= standalone_nxt;
            idx_r <= idx_nxt;
            route_r <= route_nxt;
            gca_r <= gca_nxt;
            oen_r <= oen_nxt;
        end
    end

    // output stage: every pin-facing signal is a flop, except the open-drain data outputs, which are tied low
    always_comb begin
        if (standalone_r) begin
            for (int j = 0; j < 4; j++) begin
                o_route_nxt[2*j +: 2] = 2'(j) ^ {scl_s, sda_s};
            end
            o_gain_nxt = VMX_SA_GAIN;
            o_clamp_nxt = VMX_SA_CLAMP;
            o_en_nxt = VMX_SA_OEN;
            aux_a_oe_nxt = ~gca_r[VMX_GCA_AUX_A];
            aux_b_oe_nxt = ~gca_r[VMX_GCA_AUX_B];
        end else begin
            o_route_nxt = route_r;
            o_gain_nxt = gca_r[VMX_GCA_GAIN_LSB +: 4];
            // inputs c/d have no clamp control in bus mode and stay biased
            o_clamp_nxt = {2'h0, ~gca_r[VMX_GCA_CLAMP_B], ~gca_r[VMX_GCA_CLAMP_A]};
            o_en_nxt = oen_r;
            aux_a_oe_nxt = ~gca_r[VMX_GCA_AUX_A];
            aux_b_oe_nxt = ~gca_r[VMX_GCA_AUX_B];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_input_routing <= VMX_ROUTE_RST;
            o_out_gain_sel <= VMX_GCA_RST[VMX_GCA_GAIN_LSB +: 4];
            o_clamp_en <= VMX_CLAMP_RST;
            o_out_drive_en <= VMX_OEN_RST;
            o_aux_logic_out_a_oe <= 1'b1;
            o_aux_logic_out_b_oe <= 1'b1;
            o_standalone <= 1'b0;
            sda_oe_r <= 1'b0;
            first_r <= 1'b1;
        end else begin
            o_input_routing <= o_route_nxt;
            o_out_gain_sel <= o_gain_nxt;
            o_clamp_en <= o_clamp_nxt;
            o_out_drive_en <= o_en_nxt;
            o_aux_logic_out_a_oe <= aux_a_oe_nxt;
            o_aux_logic_out_b_oe <= aux_b_oe_nxt;
            o_standalone <= standalone_r;
            sda_oe_r <= sda_oe_c;
            first_r <= 1'b0;
        end
    end

    // open-drain pins only ever pull low
    assign o_sda_out = 1'b0;
    assign o_aux_logic_out_a = 1'b0;
    assign o_aux_logic_out_b = 1'b0;
    assign o_sda_oe = sda_oe_r;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    AST_GAIN: assert property (!standalone_r |=> o_out_gain_sel == $past(gca_r[7:4]))
        else $error("gain select does not follow stored bits");
    AST_CLAMP: assert property (!standalone_r |=> o_clamp_en[1:0] == ~$past(gca_r[3:2]))
        else $error("clamp enable does not follow clamp bits");
    AST_AUX: assert property (##1 o_aux_logic_out_a_oe == ~$past(gca_r[0])
        && o_aux_logic_out_b_oe == ~$past(gca_r[1]))
        else $error("aux pull-down does not follow aux bits");
    AST_OEN_WR: assert property (dat_v && idx_r == VMX_IDX_OEN |=> oen_r == $past(rx_byte[3:0]))
        else $error("enable byte not stored from low nibble");
    AST_DRIVE: assert property (!standalone_r ##1 !standalone_r |-> o_out_drive_en == $past(oen_r))
        else $error("drive enable does not follow enable register");
    AST_RST: assert property (first_r |-> route_r == 8'h00 && oen_r == 4'h0
        && gca_r == 8'h00 && o_out_drive_en == 4'h0)
        else $error("power-on values wrong");
    AST_MODE: assert property ($rose(mode_valid_r) |-> standalone_r == (&$past(strap_s2_r)))
        else $error("mode not taken from straps");
    AST_SA_FIX: assert property (standalone_r |=> o_out_drive_en == 4'hf
        && o_clamp_en == 4'hf && o_out_gain_sel == 4'h0)
        else $error("standalone fixed settings wrong");
    AST_SA_STRAIGHT: assert property (standalone_r && !scl_s && !sda_s |=> o_input_routing == 8'he4)
        else $error("standalone straight routing wrong");
    AST_SA_SCL: assert property (standalone_r |=> o_input_routing[1] == $past(scl_s)
        && o_input_routing[7] == ~$past(scl_s))
        else $error("scl swap of output pairs wrong");
    AST_SA_SDA: assert property (standalone_r |=> o_input_routing[0] == $past(sda_s)
        && o_input_routing[2] == ~$past(sda_s))
        else $error("sda swap within pairs wrong");
    AST_ROUTE_WR: assert property (dat_v && idx_r == VMX_IDX_ROUTE |=> route_r == $past(rx_byte))
        else $error("routing byte not stored");
    AST_GCA_WR: assert property (dat_v && idx_r == VMX_IDX_GCA |=> gca_r == $past(rx_byte))
        else $error("gain clamp aux byte not stored");
    AST_WRAP: assert property (dat_v && idx_r == VMX_IDX_OEN |=> idx_r == VMX_IDX_ROUTE)
        else $error("index does not wrap after third register");
    AST_AUX_RST: assert property (first_r |-> o_aux_logic_out_a_oe && o_aux_logic_out_b_oe)
        else $error("aux outputs not low after power-up");
    AST_SA_QUIET: assert property (standalone_r |-> !sda_oe_c && !dat_v)
        else $error("standalone mode answered the bus");

    COV_ROUTE: cover property (dat_v && idx_r == VMX_IDX_ROUTE);
    COV_OEN: cover property (dat_v && idx_r == VMX_IDX_OEN ##[1:400] dat_v && idx_r == VMX_IDX_ROUTE);
    COV_SA: cover property (standalone_r && scl_s && sda_s);
    COV_ACK: cover property ($rose(o_sda_oe));
endmodule : vmx_ctrl
`default_nettype wire

// >>> inc/vmx_pkg.sv
/*
 * vmx_pkg: constants shared by the video matrix control logic.
 * assumes: included before any vmx_* module is compiled.
 */
`default_nettype none
package vmx_pkg;
    // register indices carried in the sub byte
    localparam logic [1:0] VMX_IDX_ROUTE = 2'h0;
    localparam logic [1:0] VMX_IDX_GCA = 2'h1;
    localparam logic [1:0] VMX_IDX_OEN = 2'h2;
    localparam logic [1:0] VMX_IDX_LAST = 2'h2;
    // gain_clamp_aux_ctrl field positions
    localparam int VMX_GCA_GAIN_LSB = 4;
    localparam int VMX_GCA_CLAMP_B = 3;
    localparam int VMX_GCA_CLAMP_A = 2;
    localparam int VMX_GCA_AUX_B = 1;
    localparam int VMX_GCA_AUX_A = 0;
    // output_enable_ctrl: only the low nibble is kept
    localparam int VMX_OEN_W = 4;
    // power-on values
    localparam logic [7:0] VMX_ROUTE_RST = 8'h00;
    localparam logic [7:0] VMX_GCA_RST = 8'h00;
    localparam logic [3:0] VMX_OEN_RST = 4'h0;
    localparam logic [3:0] VMX_CLAMP_RST = 4'h3;
    // edges after reset release before the synchronised straps are trusted
    localparam logic [1:0] VMX_MODE_SETTLE = 2'h2;
    // standalone mode: all outputs driven, all inputs clamped, gain two
    localparam logic [3:0] VMX_SA_OEN = 4'hf;
    localparam logic [3:0] VMX_SA_CLAMP = 4'hf;
    localparam logic [3:0] VMX_SA_GAIN = 4'h0;
    // fixed upper bits of the serial slave address, write bit last; then the bit counts of the ack slot
    localparam logic [3:0] VMX_SLV_HI = 4'h9;
    localparam logic [3:0] VMX_BIT_ACK = 4'h8;
    localparam logic [3:0] VMX_BIT_DONE = 4'h9;
endpackage : vmx_pkg
`default_nettype wire

// >>> hw/vmx_i2c_rx.sv
/*
 * vmx_i2c_rx: write-only two-wire slave receiver, oversampling the bus.
 * assumes: sys clock at least 8x the bus clock; scl/sda arrive asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none
module vmx_i2c_rx
    import vmx_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_scl,
    input wire logic i_sda_in,
    input wire logic i_enable,
    input wire logic [2:0] i_addr_lo,
    output logic o_scl_sync,
    output logic o_sda_sync,
    output logic o_sda_oe,
    output logic o_sub_valid,
    output logic o_data_valid,
    output logic [7:0] o_byte
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_SUB = 2'b10,
        ST_DATA = 2'b11
    } vmx_rx_st_t;

    logic [1:0] scl_ff_r, sda_ff_r;
    logic scl_d_r, sda_d_r;
    vmx_rx_st_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic ack_r, ack_nxt;
    logic sub_v_r, sub_v_nxt, dat_v_r, dat_v_nxt;
    logic scl_rise, scl_fall, start_c, stop_c;

    // first stage feeds only the second stage
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            scl_ff_r <= 2'h3;
            sda_ff_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_ff_r <= {scl_ff_r[0], i_scl};
            sda_ff_r <= {sda_ff_r[0], i_sda_in};
            scl_d_r <= scl_ff_r[1];
            sda_d_r <= sda_ff_r[1];
        end
    end

    assign scl_rise = scl_ff_r[1] & ~scl_d_r;
    assign scl_fall = ~scl_ff_r[1] & scl_d_r;
    assign start_c = scl_ff_r[1] & scl_d_r & sda_d_r & ~sda_ff_r[1];
    assign stop_c = scl_ff_r[1] & scl_d_r & ~sda_d_r & sda_ff_r[1];

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ack_nxt = ack_r;
        sub_v_nxt = 1'b0;
        dat_v_nxt = 1'b0;
        if (start_c) begin
            st_nxt = i_enable ? ST_ADDR : ST_IDLE;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt = ST_IDLE;
            ack_nxt = 1'b0;
        end else if (st_r != ST_IDLE) begin
            if (scl_rise && cnt_r < VMX_BIT_ACK) begin
                sh_nxt = {sh_r[6:0], sda_d_r};
                cnt_nxt = cnt_r + 4'h1;
            end else if (scl_rise && cnt_r == VMX_BIT_ACK) begin
                cnt_nxt = VMX_BIT_DONE;
            end else if (scl_fall && cnt_r == VMX_BIT_ACK) begin
                // acknowledge is driven from this fall to the next
                case (st_r)
                    ST_ADDR: begin
                        if (i_enable && sh_r == {VMX_SLV_HI, i_addr_lo, 1'b0}) begin
                            ack_nxt = 1'b1;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                    ST_SUB: begin
                        ack_nxt = 1'b1;
                        sub_v_nxt = 1'b1;
                    end
                    default: begin
                        ack_nxt = 1'b1;
                        dat_v_nxt = 1'b1;
                    end
                endcase
            end else if (scl_fall && cnt_r == VMX_BIT_DONE) begin
                ack_nxt = 1'b0;
                cnt_nxt = 4'h0;
                case (st_r)
                    ST_ADDR: st_nxt = ST_SUB;
                    ST_SUB: st_nxt = ST_DATA;
                    default: st_nxt = st_r;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ack_r <= 1'b0;
            sub_v_r <= 1'b0;
            dat_v_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ack_r <= ack_nxt;
            sub_v_r <= sub_v_nxt;
            dat_v_r <= dat_v_nxt;
        end
    end

    assign o_scl_sync = scl_d_r;
    assign o_sda_sync = sda_d_r;
    assign o_sda_oe = ack_r;
    assign o_sub_valid = sub_v_r;
    assign o_data_valid = dat_v_r;
    assign o_byte = sh_r;
endmodule : vmx_i2c_rx
`default_nettype wire

// >>> tb/vmx_bus_master.sv
/*
 * vmx_bus_master: behavioural two-wire bus master driving the control block.
 * assumes: the bench resolves the open-drain data wire and feeds it back on i_sda.
 */
`timescale 1ns/10ps
`default_nettype none
module vmx_bus_master (
    input wire logic i_clk_sys,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask : wait_clk

    // static levels for standalone mode; bus lines idle high between frames
    task automatic set_levels(input logic scl, input logic sda);
        @(negedge i_clk_sys);
        o_scl = scl;
        o_sda_pull = ~sda;
    endtask : set_levels

    // low phase 6 clocks, high phase 2: data moves one clock after the ack is dropped
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            wait_clk(5);
            o_sda_pull = ~b[i];
            wait_clk(1);
            o_scl = 1'b1;
            wait_clk(2);
            o_scl = 1'b0;
        end
        wait_clk(5);
        o_sda_pull = 1'b0;
        wait_clk(1);
        o_scl = 1'b1;
        wait_clk(1);
        ack = (i_sda === 1'b0);
        wait_clk(1);
        o_scl = 1'b0;
    endtask : put_byte

    // control bytes must be written before outputs leave high impedance
    task automatic write_frame(input logic [7:0] b[$], output int acks);
        logic ack;
        acks = 0;
        wait_clk(1);
        o_sda_pull = 1'b0;
        wait_clk(2);
        o_scl = 1'b1;
        wait_clk(3);
        o_sda_pull = 1'b1;
        wait_clk(3);
        o_scl = 1'b0;
        foreach (b[i]) begin
            put_byte(b[i], ack);
            if (ack) acks++;
        end
        wait_clk(5);
        o_sda_pull = 1'b1;
        wait_clk(1);
        o_scl = 1'b1;
        wait_clk(3);
        o_sda_pull = 1'b0;
        wait_clk(4);
    endtask : write_frame
endmodule : vmx_bus_master
`default_nettype wire

// >>> tb/testbench.sv
/*
 * testbench: self-checking bench for vmx_ctrl with a bus master partner.
 * assumes: 25 MHz system clock; straps change only around a reset.
 */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import vmx_pkg::*;
    localparam int TIME_LIMIT = 20000;
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic [2:0] strap = 3'h5;
    logic scl, sda_pull, sda_out, sda_oe, aux_a, aux_a_oe, aux_b, aux_b_oe, standalone;
    logic [7:0] routing;
    logic [3:0] gain, clamp, drive;
    wire logic sda_pin;
    wire logic aux_a_pin;
    wire logic aux_b_pin;
    int error_cnt = 0;
    int checks = 0;
    int cycles = 0;
    int acks;

    // open-drain wires with pull-ups
    assign sda_pin = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
    assign aux_a_pin = aux_a_oe ? aux_a : 1'b1;
    assign aux_b_pin = aux_b_oe ? aux_b : 1'b1;

    always #20 i_clk_sys = ~i_clk_sys;

    vmx_bus_master master_u (.i_clk_sys(i_clk_sys), .i_sda(sda_pin), .o_scl(scl), .o_sda_pull(sda_pull));

    vmx_ctrl dut_u (
        .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_scl(scl), .i_sda_in(sda_pin),
        .i_addr_strap_0(strap[0]), .i_addr_strap_1(strap[1]), .i_addr_strap_2(strap[2]),
        .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_input_routing(routing), .o_out_gain_sel(gain),
        .o_clamp_en(clamp), .o_out_drive_en(drive), .o_aux_logic_out_a(aux_a),
        .o_aux_logic_out_a_oe(aux_a_oe), .o_aux_logic_out_b(aux_b), .o_aux_logic_out_b_oe(aux_b_oe),
        .o_standalone(standalone)
    );

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_of_test

    // hang guard: a frame takes under 600 clocks, the whole run a few thousand
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == TIME_LIMIT) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic do_reset(input logic [2:0] s);
        master_u.set_levels(1'b1, 1'b1);
        strap = s;
        i_reset = 1'b1;
        repeat (8) @(negedge i_clk_sys);
        i_reset = 1'b0;
        repeat (8) @(negedge i_clk_sys);
    endtask : do_reset

    // one frame, then time for the outputs to settle
    task automatic frame(input logic [7:0] b[$], input int exp_acks);
        master_u.write_frame(b, acks);
        repeat (8) @(negedge i_clk_sys);
        check("acks", 8'(acks), 8'(exp_acks));
    endtask : frame

    task automatic check_ctrl(input logic [7:0] r, input logic [3:0] g, input logic [3:0] c, input logic [3:0] d);
        check("routing", routing, r);
        check("gain", {4'h0, gain}, {4'h0, g});
        check("clamp", {4'h0, clamp}, {4'h0, c});
        check("drive", {4'h0, drive}, {4'h0, d});
    endtask : check_ctrl

    function automatic logic [7:0] sa_route(input logic [1:0] sel);
        logic [7:0] r;
        for (int j = 0; j < 4; j++) r[2*j +: 2] = 2'(j) ^ sel;
        return r;
    endfunction : sa_route

    task automatic test_reset_values();
        check_ctrl(8'h00, 4'h0, 4'h3, 4'h0);
        check("aux pins", {6'h0, aux_b_pin, aux_a_pin}, 8'h00);
        check("standalone", {7'h0, standalone}, 8'h00);
        $display("test_reset_values done");
    endtask : test_reset_values

    // four data bytes from index 0: the fourth wraps onto the routing byte
    task automatic test_bus_write();
        frame('{8'h9a, 8'h00, 8'he4, 8'ha6, 8'hf5, 8'h1b}, 6);
        check_ctrl(8'h1b, 4'ha, 4'h2, 4'h5);
        check("aux pins", {6'h0, aux_b_pin, aux_a_pin}, 8'h02);
        $display("test_bus_write done");
    endtask : test_bus_write

    task automatic test_sub2();
        frame('{8'h9a, 8'h02, 8'h3a, 8'h55}, 4);
        check_ctrl(8'h55, 4'ha, 4'h2, 4'ha);
        frame('{8'h9a, 8'h01, 8'h5f}, 3);
        check_ctrl(8'h55, 4'h5, 4'h0, 4'ha);
        check("aux pins", {6'h0, aux_b_pin, aux_a_pin}, 8'h03);
        $display("test_sub2 done");
    endtask : test_sub2

    // wrong address and a read request are both left unanswered
    task automatic test_refused();
        frame('{8'h98, 8'h00, 8'hff}, 0);
        frame('{8'h9b, 8'h00}, 0);
        check_ctrl(8'h55, 4'h5, 4'h0, 4'ha);
        // index 3 holds no register: its byte is dropped and the next lands on routing
        frame('{8'h9a, 8'h03, 8'hff, 8'h66}, 4);
        check_ctrl(8'h66, 4'h5, 4'h0, 4'ha);
        $display("test_refused done");
    endtask : test_refused

    task automatic test_standalone();
        logic [1:0] sel;
        do_reset(3'h7);
        check("standalone", {7'h0, standalone}, 8'h01);
        for (int k = 0; k < 4; k++) begin
            sel = 2'(k);
            master_u.set_levels(sel[1], sel[0]);
            repeat (8) @(negedge i_clk_sys);
            check_ctrl(sa_route(sel), 4'h0, 4'hf, 4'hf);
        end
        frame('{8'h9e, 8'h00, 8'he4}, 0);
        check_ctrl(sa_route(2'h3), 4'h0, 4'hf, 4'hf);
        do_reset(3'h3);
        check("standalone", {7'h0, standalone}, 8'h00);
        $display("test_standalone done");
    endtask : test_standalone

    initial begin
        do_reset(3'h5);
        test_reset_values();
        test_bus_write();
        test_sub2();
        test_refused();
        test_standalone();
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
